// >>> bench/an_engine_model.sv
// negotiation engine model driving received pages and status levels
`timescale 1ns/1ps
`default_nettype none
module an_engine_model
    import phy_an_pkg::*;
(
    input wire logic clk,
    output an_status_t an_status
);
    initial an_status = '0;
    // data lines go to the inverse once a load pulse is over
    task automatic load_base(input logic [15:0] p);
        @(posedge clk);
        an_status.base_load <= 1'b1;
        an_status.base_page <= p;
        @(posedge clk);
        an_status.base_load <= 1'b0;
        an_status.base_page <= ~p;
    endtask
    task automatic load_np(input logic [15:0] p);
        @(posedge clk);
        an_status.np_load <= 1'b1;
        an_status.next_page <= p;
        @(posedge clk);
        an_status.np_load <= 1'b0;
        an_status.next_page <= ~p;
    endtask
    task automatic set_levels(input logic np_able, an_able, fault, page, toggle);
        @(posedge clk);
        an_status.partner_np_able <= np_able;
        an_status.partner_an_able <= an_able;
        an_status.parallel_fault <= fault;
        an_status.page_received <= page;
        an_status.tx_toggle_prev <= toggle;
    endtask
endmodule
`default_nettype wire

// >>> bench/phy_an_id_bank_test.sv
// self-checking bench for the negotiation register bank
`timescale 1ns/1ps
`default_nettype none
module phy_an_id_bank_test
    import phy_an_pkg::*;
;
    // arbitrary identity values
    localparam logic [21:0] ORG_ID = 22'h1B3E47;
    localparam logic [5:0] MODEL = 6'h2C;
    localparam logic [3:0] REV = 4'h6;
    localparam logic [5:0] STRAP = 6'h2D;
    logic clk, reset_n, mgmt_rvalid, np_tx_written, np_seen;
    mgmt_req_t mgmt_req;
    an_status_t an_status;
    logic [5:0] config_strap;
    logic [15:0] mgmt_rdata, local_advert, np_tx_word, rd;
    logic [15:0] exp_bank [0:8];
    int failures, samples_checked;

    phy_an_id_bank #(.ORGANIZATION_IDENTIFIER(ORG_ID), .MODEL_NUMBER(MODEL),
        .REVISION_NUMBER(REV)) dut_u (.clk(clk), .reset_n(reset_n), .mgmt_req(mgmt_req),
        .an_status(an_status), .config_strap(config_strap), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid), .local_advert(local_advert), .np_tx_word(np_tx_word),
        .np_tx_written(np_tx_written));
    an_engine_model eng_u (.clk(clk), .an_status(an_status));

    always #20 clk = ~clk;

    task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic mgmt_read(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        mgmt_req.read <= 1'b1;
        mgmt_req.addr <= a;
        @(posedge clk);
        mgmt_req.read <= 1'b0;
        @(negedge clk);
        check_bit("rvalid", 1'b1, mgmt_rvalid);
        d = mgmt_rdata;
    endtask
    task automatic mgmt_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        mgmt_req.write <= 1'b1;
        mgmt_req.addr <= a;
        mgmt_req.wdata <= d;
        @(posedge clk);
        mgmt_req.write <= 1'b0;
        mgmt_req.wdata <= ~d;
        @(negedge clk);
        np_seen = np_tx_written;
    endtask
    task automatic sweep();
        for (int a = 0; a <= 8; a++) begin
            mgmt_read(5'(a), rd);
            check_word($sformatf("reg%0d", a), exp_bank[a], rd);
        end
    endtask

    task automatic test_reset_values();
        foreach (exp_bank[i]) exp_bank[i] = '0;
        exp_bank[2] = ORG_ID[21:6];
        exp_bank[3] = {ORG_ID[5:0], MODEL, REV};
        exp_bank[4] = {4'h0, STRAP[5:4], 1'b0, STRAP[3:0], 5'h01};
        exp_bank[6] = 16'h0004;
        exp_bank[7] = 16'h2801;
        check_word("advert port", exp_bank[4], local_advert);
        check_word("np tx port", 16'h2001, np_tx_word);
        sweep();
    endtask
    task automatic test_write_masks();
        for (int a = 0; a <= 8; a++) begin
            mgmt_write(5'(a), 16'hFFFF);
            check_bit("np written", a == 7, np_seen);
        end
        mgmt_write(5'h1F, 16'hFFFF);
        exp_bank[4] = 16'hBFFF;
        exp_bank[7] = 16'hBFFF;
        check_word("advert port", 16'hBFFF, local_advert);
        check_word("np tx port", 16'hB7FF, np_tx_word);
        sweep();
        mgmt_read(5'h1F, rd);
        check_word("unmapped", 16'h0000, rd);
        mgmt_write(5'h04, 16'h0000);
        mgmt_write(5'h07, 16'h0000);
        mgmt_read(5'h04, rd);
        check_word("reg4 cleared", 16'h0000, rd);
        mgmt_read(5'h07, rd);
        check_word("reg7 cleared", 16'h0800, rd);
    endtask
    task automatic test_partner_pages();
        eng_u.load_base(16'hA5C3);
        mgmt_read(5'h05, rd);
        check_word("reg5 loaded", 16'hA5C3, rd);
        eng_u.load_np(16'h5A3C);
        eng_u.load_base(16'h7E81);
        mgmt_read(5'h08, rd);
        check_word("reg8 loaded", 16'h5A3C, rd);
        mgmt_read(5'h05, rd);
        check_word("reg5 reloaded", 16'h7E81, rd);
        // read strobe in the cycle right after the load pulse
        fork
            eng_u.load_base(16'h3C96);
            begin
                @(posedge clk);
                mgmt_read(5'h05, rd);
            end
        join
        check_word("reg5 next cycle", 16'h3C96, rd);
    endtask
    task automatic read_exp(input logic [15:0] exp);
        mgmt_read(5'h06, rd);
        check_word("reg6", exp, rd);
    endtask
    task automatic test_expansion();
        eng_u.set_levels(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        eng_u.set_levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        read_exp(16'h001D);
        read_exp(16'h000D);
        eng_u.set_levels(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        read_exp(16'h000D);
        read_exp(16'h000F);
        // a one-cycle drop must still be seen
        eng_u.set_levels(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        eng_u.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        read_exp(16'h0004);
        read_exp(16'h0006);
        // a fault still standing in the read cycle survives the read
        eng_u.set_levels(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        read_exp(16'h0016);
        eng_u.set_levels(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        read_exp(16'h0016);
        read_exp(16'h0006);
    endtask
    task automatic test_toggle();
        for (int t = 0; t < 2; t++) begin
            eng_u.set_levels(1'b0, 1'b0, 1'b0, 1'b1, t[0]);
            repeat (3) @(posedge clk);
            mgmt_read(5'h07, rd);
            check_word("reg7 toggle", {4'h0, ~t[0], 11'h000}, rd);
        end
    endtask

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        mgmt_req = '0;
        config_strap = STRAP;
        failures = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        test_reset_values();
        test_write_masks();
        test_partner_pages();
        test_expansion();
        test_toggle();
        final_report();
    end
    // the whole sequence takes well under two thousand cycles
    initial begin
        #(40 * 20000);
        failures++;
        final_report();
    end
endmodule
`default_nettype wire

// >>> rtl/latch_status_bit.sv
// status bit that holds its latching level until software reads it
`timescale 1ns/1ps
`default_nettype none
module latch_status_bit #(
    parameter bit LATCH_LEVEL = 1'b1,
    parameter bit RESET_VALUE = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic live,
    input wire logic read_strobe,
    output logic latched
);
    logic state;
    logic next_state;

    // a read reloads from the live level, so an event in the read cycle survives
    always_comb begin
        next_state = state;
        if (read_strobe) begin
            next_state = live;
        end else if (live == LATCH_LEVEL) begin
            next_state = LATCH_LEVEL;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= RESET_VALUE;
        end else begin
            state <= next_state;
        end
    end

    assign latched = state;
endmodule
`default_nettype wire

// >>> rtl/phy_an_id_bank.sv
// identification and negotiation register bank, addresses 2 to 8
`timescale 1ns/1ps
`default_nettype none
`include "phy_an_regs.svh"
module phy_an_id_bank
    import phy_an_pkg::*;
#(
    // arbitrary neutral identity values
    parameter logic [21:0] ORGANIZATION_IDENTIFIER = 22'h2A5C93,
    parameter logic [5:0] MODEL_NUMBER = 6'h15,
    parameter logic [3:0] REVISION_NUMBER = 4'h9
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire mgmt_req_t mgmt_req,
    input wire an_status_t an_status,
    input wire logic [5:0] config_strap,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    output logic [15:0] local_advert,
    output logic [15:0] np_tx_word,
    output logic np_tx_written
);
    bank_state_t st;
    bank_state_t next_st;
    logic fault_latched;
    logic page_latched;
    logic exp_read;
    logic [15:0] id_high;
    logic [15:0] id_low;
    logic [15:0] exp_word;

    assign exp_read = mgmt_req.read && (mgmt_req.addr == `ADDR_NEGOTIATION_EXPANSION);
    assign id_high = ORGANIZATION_IDENTIFIER[21:6];
    assign id_low = {ORGANIZATION_IDENTIFIER[5:0], MODEL_NUMBER, REVISION_NUMBER};

    latch_status_bit #(.LATCH_LEVEL(1'b1), .RESET_VALUE(1'b0)) fault_bit (
        .clk(clk),
        .reset_n(reset_n),
        .live(an_status.parallel_fault),
        .read_strobe(exp_read),
        .latched(fault_latched)
    );

    latch_status_bit #(.LATCH_LEVEL(1'b0), .RESET_VALUE(1'b0)) page_bit (
        .clk(clk),
        .reset_n(reset_n),
        .live(an_status.page_received),
        .read_strobe(exp_read),
        .latched(page_latched)
    );

    always_comb begin
        exp_word = 16'h0000;
        exp_word[`EXP_BIT_PARALLEL_FAULT] = fault_latched;
        exp_word[`EXP_BIT_PARTNER_NP_ABLE] = st.partner_np_able;
        exp_word[`EXP_BIT_LOCAL_NP_ABLE] = `LOCAL_NP_ABLE;
        exp_word[`EXP_BIT_PAGE_RECEIVED] = page_latched;
        exp_word[`EXP_BIT_PARTNER_AN_ABLE] = st.partner_an_able;
    end

    always_comb begin
        next_st = st;
        next_st.np_tx_written = 1'b0;
        next_st.rvalid = mgmt_req.read;
        // strap pins pass two flops before use
        next_st.strap_s1 = config_strap;
        next_st.strap_s2 = st.strap_s1;
        next_st.partner_np_able = an_status.partner_np_able;
        next_st.partner_an_able = an_status.partner_an_able;
        next_st.toggle_rd = ~an_status.tx_toggle_prev;
        if (st.load_count != `STRAP_LOAD_DONE) begin
            next_st.load_count = st.load_count + 2'h1;
        end
        // capture waits until the synchroniser holds post-release strap levels
        if (st.load_count == `STRAP_LOAD_CYCLE) begin
            next_st.advert[`ADVERT_BIT_ASYM_PAUSE] = st.strap_s2[5];
            next_st.advert[`ADVERT_BIT_SYM_PAUSE] = st.strap_s2[4];
            next_st.advert[8:`ADVERT_STRAP_LOW_BIT] = st.strap_s2[3:0];
        end
        if (an_status.base_load) begin
            next_st.partner_base = an_status.base_page;
        end
        if (an_status.np_load) begin
            next_st.partner_np = an_status.next_page;
        end
        if (mgmt_req.write) begin
            unique case (mgmt_req.addr)
                `ADDR_LOCAL_ABILITY_ADVERT: begin
                    next_st.advert = mgmt_req.wdata & `ADVERT_WRITE_MASK;
                end
                `ADDR_NEXT_PAGE_TRANSMIT: begin
                    next_st.np_tx = mgmt_req.wdata & `NP_TX_WRITE_MASK;
                    next_st.np_tx_written = 1'b1;
                end
                default: begin
                    // read-only and unmapped addresses drop the write
                end
            endcase
        end
        next_st.rdata = 16'h0000;
        if (mgmt_req.read) begin
            unique case (mgmt_req.addr)
                `ADDR_IDENTIFIER_HIGH: next_st.rdata = id_high;
                `ADDR_IDENTIFIER_LOW: next_st.rdata = id_low;
                `ADDR_LOCAL_ABILITY_ADVERT: next_st.rdata = st.advert;
                `ADDR_PARTNER_BASE_ABILITY: next_st.rdata = st.partner_base;
                `ADDR_NEGOTIATION_EXPANSION: next_st.rdata = exp_word;
                `ADDR_NEXT_PAGE_TRANSMIT: begin
                    next_st.rdata = st.np_tx;
                    next_st.rdata[`NP_TX_BIT_TOGGLE] = st.toggle_rd;
                end
                `ADDR_PARTNER_NEXT_PAGE_RECEIVE: next_st.rdata = st.partner_np;
                default: next_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
            st.advert <= `ADVERT_RESET;
            st.np_tx <= `NP_TX_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign mgmt_rdata = st.rdata;
    assign mgmt_rvalid = st.rvalid;
    assign local_advert = st.advert;
    assign np_tx_word = st.np_tx;
    assign np_tx_written = st.np_tx_written;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_ID_HIGH: assert property (
        mgmt_req.read && mgmt_req.addr == `ADDR_IDENTIFIER_HIGH
        |=> mgmt_rvalid && mgmt_rdata == ORGANIZATION_IDENTIFIER[21:6])
        else $error("identifier high word wrong");

    AST_ID_LOW: assert property (
        mgmt_req.read && mgmt_req.addr == `ADDR_IDENTIFIER_LOW
        |=> mgmt_rdata[15:10] == ORGANIZATION_IDENTIFIER[5:0]
            && mgmt_rdata[9:4] == MODEL_NUMBER && mgmt_rdata[3:0] == REVISION_NUMBER)
        else $error("identifier low word wrong");

    AST_ADVERT_RESERVED: assert property (
        local_advert[`ADVERT_BIT_RESERVED] == 1'b0)
        else $error("advert reserved bit set");

    AST_ADVERT_WRITE: assert property (
        mgmt_req.write && mgmt_req.addr == `ADDR_LOCAL_ABILITY_ADVERT
        |=> local_advert == ($past(mgmt_req.wdata) & `ADVERT_WRITE_MASK))
        else $error("advert write not stored");

    AST_STRAP_CAPTURE: assert property (
        st.load_count == `STRAP_LOAD_CYCLE && !mgmt_req.write
        |=> local_advert[11:10] == $past(st.strap_s2[5:4])
            && local_advert[8:5] == $past(st.strap_s2[3:0])
            && local_advert[9] == 1'b0)
        else $error("strap capture wrong");

    AST_PARTNER_BASE: assert property (
        an_status.base_load ##1 mgmt_req.read && mgmt_req.addr == `ADDR_PARTNER_BASE_ABILITY
        && !an_status.base_load
        |=> mgmt_rdata == $past(an_status.base_page, 2))
        else $error("partner base page not mirrored");

    AST_FAULT_HOLD: assert property (
        fault_latched && !exp_read |=> fault_latched)
        else $error("parallel fault dropped before read");

    AST_PAGE_LOW_HOLD: assert property (
        !page_latched && !exp_read |=> !page_latched)
        else $error("page received low not held");

    AST_EXPANSION_FIXED: assert property (
        exp_read |=> mgmt_rdata[15:5] == 11'h000 && mgmt_rdata[2] == 1'b1)
        else $error("expansion fixed bits wrong");

    AST_TOGGLE: assert property (
        mgmt_req.read && mgmt_req.addr == `ADDR_NEXT_PAGE_TRANSMIT
        |=> mgmt_rdata[11] == !$past(an_status.tx_toggle_prev, 2) && mgmt_rdata[14] == 1'b0)
        else $error("toggle bit wrong");

    AST_NP_WRITE: assert property (
        mgmt_req.write && mgmt_req.addr == `ADDR_NEXT_PAGE_TRANSMIT
        |=> np_tx_written && np_tx_word == ($past(mgmt_req.wdata) & `NP_TX_WRITE_MASK))
        else $error("next page write not stored");

    AST_PARTNER_NP: assert property (
        an_status.np_load |=> st.partner_np == $past(an_status.next_page))
        else $error("partner next page not mirrored");

    AST_RO_IGNORED: assert property (
        mgmt_req.write && mgmt_req.addr == `ADDR_PARTNER_BASE_ABILITY && !an_status.base_load
        |=> $stable(st.partner_base))
        else $error("write to read-only register took effect");

    AST_RESET_VALUES: assert property (
        $rose(reset_n)
        |-> local_advert == `ADVERT_RESET && np_tx_word == `NP_TX_RESET && !np_tx_written)
        else $error("register reset values wrong");

    AST_PARTNER_RESET: assert property (
        $rose(reset_n)
        |-> st.partner_base == 16'h0000 && st.partner_np == 16'h0000 && !fault_latched)
        else $error("partner words or latches not cleared by reset");

    AST_ADVERT_HOLD: assert property (
        !(mgmt_req.write && mgmt_req.addr == `ADDR_LOCAL_ABILITY_ADVERT)
        && st.load_count != `STRAP_LOAD_CYCLE
        |=> $stable(local_advert))
        else $error("advert changed without a write");

    AST_READ_ADVERT: assert property (
        mgmt_req.read && mgmt_req.addr == `ADDR_LOCAL_ABILITY_ADVERT
        |=> mgmt_rdata == $past(local_advert))
        else $error("advert read back wrong");

    AST_NP_TX_HOLD: assert property (
        !(mgmt_req.write && mgmt_req.addr == `ADDR_NEXT_PAGE_TRANSMIT)
        |=> $stable(np_tx_word))
        else $error("next page word changed without a write");

    AST_NP_TX_FIXED: assert property (
        np_tx_word[`NP_TX_BIT_RESERVED] == 1'b0 && np_tx_word[`NP_TX_BIT_TOGGLE] == 1'b0)
        else $error("next page read-only bits stored");

    AST_NP_WRITTEN_ONLY: assert property (
        np_tx_written
        |-> $past(mgmt_req.write) && $past(mgmt_req.addr) == `ADDR_NEXT_PAGE_TRANSMIT)
        else $error("next page strobe without a write");

    AST_READ_ANSWER: assert property (
        mgmt_rvalid == $past(mgmt_req.read))
        else $error("read answer not one cycle after the strobe");

    AST_IDLE_RDATA: assert property (
        !mgmt_rvalid |-> mgmt_rdata == 16'h0000)
        else $error("read data not zero between answers");

    AST_UNMAPPED_READ: assert property (
        mgmt_req.read && (mgmt_req.addr < `ADDR_IDENTIFIER_HIGH
            || mgmt_req.addr > `ADDR_PARTNER_NEXT_PAGE_RECEIVE)
        |=> mgmt_rvalid && mgmt_rdata == 16'h0000)
        else $error("unmapped read not zero");

    AST_PARTNER_BASE_HOLD: assert property (
        !an_status.base_load |=> $stable(st.partner_base))
        else $error("partner base page changed without a load");

    AST_PARTNER_NP_HOLD: assert property (
        !an_status.np_load |=> $stable(st.partner_np))
        else $error("partner next page changed without a load");

    AST_READ_PARTNER_NP: assert property (
        mgmt_req.read && mgmt_req.addr == `ADDR_PARTNER_NEXT_PAGE_RECEIVE
        |=> mgmt_rdata == $past(st.partner_np))
        else $error("partner next page read back wrong");

    AST_FAULT_SET: assert property (
        an_status.parallel_fault |=> fault_latched)
        else $error("parallel fault not latched");

    AST_PAGE_CLEAR: assert property (
        !an_status.page_received |=> !page_latched)
        else $error("page received low not latched");

    AST_PARTNER_ABLE: assert property (
        exp_read
        |=> mgmt_rdata[`EXP_BIT_PARTNER_NP_ABLE] == $past(an_status.partner_np_able, 2)
            && mgmt_rdata[`EXP_BIT_PARTNER_AN_ABLE] == $past(an_status.partner_an_able, 2))
        else $error("partner ability flags wrong");

    AST_LATCH_READ_BITS: assert property (
        exp_read
        |=> mgmt_rdata[`EXP_BIT_PARALLEL_FAULT] == $past(fault_latched)
            && mgmt_rdata[`EXP_BIT_PAGE_RECEIVED] == $past(page_latched))
        else $error("latched expansion bits read back wrong");

    CVR_NP_WRITE: cover property (mgmt_req.write && mgmt_req.addr == `ADDR_NEXT_PAGE_TRANSMIT);
    CVR_FAULT_READ: cover property (fault_latched && exp_read ##1 !fault_latched);
    CVR_EVENT_ON_READ: cover property (exp_read && an_status.parallel_fault);
    CVR_BASE_LOAD: cover property (an_status.base_load ##1 mgmt_req.read);
    CVR_STRAP_LOAD: cover property (st.load_count == `STRAP_LOAD_CYCLE);
endmodule
`default_nettype wire

// >>> rtl/phy_an_pkg.sv
// types shared by the negotiation register bank
package phy_an_pkg;
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic base_load;
        logic [15:0] base_page;
        logic np_load;
        logic [15:0] next_page;
        logic partner_np_able;
        logic partner_an_able;
        logic parallel_fault;
        logic page_received;
        logic tx_toggle_prev;
    } an_status_t;

    typedef struct packed {
        logic [15:0] advert;
        logic [15:0] np_tx;
        logic [15:0] partner_base;
        logic [15:0] partner_np;
        logic partner_np_able;
        logic partner_an_able;
        logic toggle_rd;
        logic [15:0] rdata;
        logic rvalid;
        logic np_tx_written;
        logic [5:0] strap_s1;
        logic [5:0] strap_s2;
        logic [1:0] load_count;
    } bank_state_t;
endpackage

// >>> rtl/phy_an_regs.svh
// offsets, field positions, reset values and masks of the negotiation register bank
`ifndef PHY_AN_REGS_SVH
`define PHY_AN_REGS_SVH

`define ADDR_IDENTIFIER_HIGH 5'h02
`define ADDR_IDENTIFIER_LOW 5'h03
`define ADDR_LOCAL_ABILITY_ADVERT 5'h04
`define ADDR_PARTNER_BASE_ABILITY 5'h05
`define ADDR_NEGOTIATION_EXPANSION 5'h06
`define ADDR_NEXT_PAGE_TRANSMIT 5'h07
`define ADDR_PARTNER_NEXT_PAGE_RECEIVE 5'h08

`define ADVERT_RESET 16'h0001
`define ADVERT_WRITE_MASK 16'hBFFF
`define ADVERT_BIT_ASYM_PAUSE 11
`define ADVERT_BIT_SYM_PAUSE 10
`define ADVERT_STRAP_LOW_BIT 5
`define ADVERT_BIT_RESERVED 14

`define NP_TX_RESET 16'h2001
`define NP_TX_WRITE_MASK 16'hB7FF
`define NP_TX_BIT_TOGGLE 11
`define NP_TX_BIT_RESERVED 14

`define EXP_BIT_PARALLEL_FAULT 4
`define EXP_BIT_PARTNER_NP_ABLE 3
`define EXP_BIT_LOCAL_NP_ABLE 2
`define EXP_BIT_PAGE_RECEIVED 1
`define EXP_BIT_PARTNER_AN_ABLE 0
`define LOCAL_NP_ABLE 1'h1

`define STRAP_WIDTH 6
`define STRAP_LOAD_CYCLE 2'h2
`define STRAP_LOAD_DONE 2'h3

`endif
